// [spi_status_consts.svh]
// register map, field positions and sizes of the serial port status block
// assumes a 32-bit classic wishbone bus with word-aligned byte addresses
`ifndef SPI_STATUS_CONSTS_SVH
`define SPI_STATUS_CONSTS_SVH
`define ADR_STAT_LOW 5'h00
`define ADR_COUNTS 5'h04
`define ADR_EVT_EN 5'h08
`define ADR_WMARK 5'h0c
`define ADR_CTRL 5'h10
`define ADR_DATA 5'h14
`define FIFO_DEPTH 6'h08
`define CNT_IMPL 6'h0f
`define STAT_MASK 16'h19eb
`define WMARK_MASK 16'hbfbf
`define CTRL_MASK 16'h000f
`define B_FERR 12
`define B_BUSY 11
`define B_TUR 8
`define B_SHIFT_REG_EMPTY_FLAG 7
`define B_ROV 6
`define B_RBE 5
`define B_TBE 3
`define B_TBF 1
`define B_RBF 0
`define B_RXWEN 15
`define B_TXWEN 7
`define C_EN 0
`define C_FIFO 1
`define C_IGN_UR 2
`define C_IGN_OV 3
`endif

// [spi_status_pkg.sv]
// types shared by the serial port status block
// assumes nothing beyond the constants header
`default_nettype none
package spi_status_pkg;
  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_SHIFT = 3'b010,
    LINK_HALT = 3'b100
  } link_state_e;
endpackage
`default_nettype wire

// [fifo_if.sv]
// carrier between the status block and one of its byte fifos
// assumes both ends run on the same clock
`default_nettype none
interface fifo_if;
  logic push;
  logic pop;
  logic flush;
  logic cap_one;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [5:0] count;
  modport ctrl (output push, pop, flush, cap_one, wdata, input rdata, count);
  modport store (input push, pop, flush, cap_one, wdata, output rdata, count);
endinterface
`default_nettype wire

// [status_fifo.sv]
// byte fifo in flip-flops; capacity one in single-buffer mode, full depth otherwise
// assumes push and pop come from logic on the same clock
`include "spi_status_consts.svh"
`default_nettype none
module status_fifo (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control side
  fifo_if.store f
);
  logic [7:0] mem_ff [8];
  logic [7:0] nxt_mem [8];
  logic [2:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [5:0] cap;
  logic do_push, do_pop;

  always_comb begin
    cap = f.cap_one ? 6'h01 : `FIFO_DEPTH;
    do_pop = f.pop && (cnt_ff != 6'h00);
    do_push = f.push && ((cnt_ff < cap) || do_pop);
    nxt_wr = do_push ? wr_ff + 3'h1 : wr_ff;
    nxt_rd = do_pop ? rd_ff + 3'h1 : rd_ff;
    nxt_cnt = cnt_ff + {5'h00, do_push} - {5'h00, do_pop};
    if (f.flush) begin
      nxt_wr = 3'h0;
      nxt_rd = 3'h0;
      nxt_cnt = 6'h00;
    end
  end

  genvar i;
  for (i = 0; i < 8; i++) begin : g_entry
    always_comb begin
      nxt_mem[i] = (do_push && wr_ff == 3'(i)) ? f.wdata : mem_ff[i];
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_ff[i] <= 8'h00;
      end else begin
        mem_ff[i] <= nxt_mem[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff <= 3'h0;
      rd_ff <= 3'h0;
      cnt_ff <= 6'h00;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  assign f.rdata = mem_ff[rd_ff];
  assign f.count = cnt_ff;
endmodule
`default_nettype wire

// [spi_status_top.sv]
// serial port slave with status flags, fifo counts and event masking
// assumes a classic wishbone master on REF_CLK and an external mode-0 master
// Operation
// RULE1 - frame error flag sets when a frame ends mid-word
// RULE2 - activity flag shows a transaction in progress
// RULE3 - underrun flag sets when a word starts with no transmit data
// RULE4 - underrun cleared by disable; with ignore it tracks live state, no halt
// RULE5 - shift-register empty only when transmit buffer and shifter hold nothing
// RULE6 - overflow flag sets when a word completes into a full receive buffer
// RULE7 - single-buffer mode: data read sets rx empty, shifter transfer clears it
// RULE8 - single-buffer mode: shifter transfer sets rx full, data read clears it
// RULE9 - single-buffer mode: move to shifter sets tx empty, data write clears it
// RULE10 - single-buffer mode: data write sets tx full, move to shifter clears it
// RULE11 - fifo mode: empty means count zero, full means count at capacity
// RULE12 - read-only rx and tx element counts in high and low halves
// RULE13 - count bit 3 exists for depth 8, bits 4 and 5 for larger depths
// RULE14 - each status flag has an enable bit letting it raise the event
// RULE15 - rx watermark event when enabled and level at most rx count
// RULE16 - tx watermark event when enabled and level equals tx count
// RULE17 - no watermark match for a level above the fifo depth
// RULE18 - unimplemented status and mask bits read as zero
// RULE19 - overflow halts unless ignore-overflow; then data is dropped
// RULE20 - fifo mode enable chooses single-buffer or count-based flags
// RULE21 - event output is the OR of all enabled sources
`include "spi_status_consts.svh"
`default_nettype none
module spi_status_top
  import spi_status_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [4:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // serial link
  input wire logic SCK,
  input wire logic SS_N,
  input wire logic SDI,
  output logic SDO,
  output logic SDO_OE,
  // event
  output logic EVENT_O
);
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [2:0] sck_ff, ss_ff, sdi_ff;
  logic sck_rise, sck_fall, ss_act, sdi_s;

  link_state_e state_ff, nxt_state;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] rxsh_ff, nxt_rxsh, txsh_ff, nxt_txsh, rx_word;
  logic loaded_ff, nxt_loaded, pend_ff, nxt_pend;
  logic ferr_ff, nxt_ferr, tur_ff, nxt_tur, rov_ff, nxt_rov;
  logic [15:0] ctrl_ff, nxt_ctrl, evt_ff, nxt_evt, wm_ff, nxt_wm;
  logic ack_ff, nxt_ack, sdo_ff, nxt_sdo, oe_ff, nxt_oe, event_ff, nxt_event;
  logic [31:0] dat_ff, nxt_dat;

  logic en, fifo_mode, ign_ur, ign_ov;
  logic bus_hit, wr_now, rd_now, byte_done, take_tx;
  logic [15:0] wmask, stat_low, stat_high, rd_val;
  logic [5:0] rx_cnt, tx_cnt, cap, rx_lvl, tx_lvl;
  logic rx_empty, rx_full, tx_empty, tx_full, rx_wm, tx_wm;

  fifo_if rx_f ();
  fifo_if tx_f ();

  status_fifo u_rx_fifo (.clk(REF_CLK), .rst_n(rst_n), .f(rx_f));
  status_fifo u_tx_fifo (.clk(REF_CLK), .rst_n(rst_n), .f(tx_f));

  // reset release and pin synchronisers; only stages 1 and 2 are read
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sck_ff <= 3'b000;
      ss_ff <= 3'b111;
      sdi_ff <= 3'b000;
    end else begin
      sck_ff <= {sck_ff[1:0], SCK};
      ss_ff <= {ss_ff[1:0], SS_N};
      sdi_ff <= {sdi_ff[1:0], SDI};
    end
  end

  always_comb begin
    sck_rise = sck_ff[1] && !sck_ff[2];
    sck_fall = !sck_ff[1] && sck_ff[2];
    ss_act = !ss_ff[1];
    sdi_s = sdi_ff[1];
  end

  // status view
  always_comb begin
    en = ctrl_ff[`C_EN];
    fifo_mode = ctrl_ff[`C_FIFO];
    ign_ur = ctrl_ff[`C_IGN_UR];
    ign_ov = ctrl_ff[`C_IGN_OV];
    rx_cnt = rx_f.count & `CNT_IMPL; // RULE13
    tx_cnt = tx_f.count & `CNT_IMPL; // RULE13
    cap = fifo_mode ? `FIFO_DEPTH : 6'h01; // RULE20
    rx_empty = (rx_cnt == 6'h00); // RULE7 RULE11
    rx_full = (rx_cnt == cap); // RULE8 RULE11
    tx_empty = (tx_cnt == 6'h00); // RULE9 RULE11
    tx_full = (tx_cnt == cap); // RULE10 RULE11
    stat_low = 16'h0000;
    stat_low[`B_FERR] = ferr_ff; // RULE1
    stat_low[`B_BUSY] = ss_act || (state_ff == LINK_SHIFT); // RULE2
    stat_low[`B_TUR] = tur_ff; // RULE3
    stat_low[`B_SHIFT_REG_EMPTY_FLAG] = tx_empty && !loaded_ff; // RULE5
    stat_low[`B_ROV] = rov_ff; // RULE6
    stat_low[`B_RBE] = rx_empty;
    stat_low[`B_TBE] = tx_empty;
    stat_low[`B_TBF] = tx_full;
    stat_low[`B_RBF] = rx_full;
    stat_high = {2'b00, rx_cnt, 2'b00, tx_cnt}; // RULE12
    rx_lvl = wm_ff[13:8];
    tx_lvl = wm_ff[5:0];
    rx_wm = wm_ff[`B_RXWEN] && (rx_lvl <= rx_cnt) && (rx_lvl <= `FIFO_DEPTH); // RULE15 RULE17
    tx_wm = wm_ff[`B_TXWEN] && (tx_lvl == tx_cnt) && (tx_lvl <= `FIFO_DEPTH); // RULE16 RULE17
    case (WB_ADR_I)
      `ADR_STAT_LOW: rd_val = stat_low & `STAT_MASK; // RULE18
      `ADR_COUNTS: rd_val = stat_high;
      `ADR_EVT_EN: rd_val = evt_ff;
      `ADR_WMARK: rd_val = wm_ff;
      `ADR_CTRL: rd_val = ctrl_ff;
      `ADR_DATA: rd_val = {8'h00, rx_f.rdata};
      default: rd_val = 16'h0000;
    endcase
  end

  // bus, flags and link shifter
  always_comb begin
    nxt_state = state_ff;
    nxt_bit = bit_ff;
    nxt_rxsh = rxsh_ff;
    nxt_txsh = txsh_ff;
    nxt_loaded = loaded_ff;
    nxt_pend = pend_ff;
    nxt_ferr = ferr_ff;
    nxt_tur = tur_ff;
    nxt_rov = rov_ff;
    nxt_ctrl = ctrl_ff;
    nxt_evt = evt_ff;
    nxt_wm = wm_ff;
    nxt_dat = dat_ff;
    rx_word = {rxsh_ff[6:0], sdi_s};
    byte_done = 1'b0;
    take_tx = 1'b0;
    wmask = {{8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    bus_hit = WB_CYC_I && WB_STB_I;
    nxt_ack = bus_hit && !ack_ff;
    // effects land on the edge where the master sees ack
    wr_now = bus_hit && ack_ff && WB_WE_I;
    rd_now = bus_hit && ack_ff && !WB_WE_I;
    if (bus_hit && !ack_ff) begin
      nxt_dat = {16'h0000, rd_val};
    end
    rx_f.push = 1'b0;
    rx_f.pop = rd_now && (WB_ADR_I == `ADR_DATA); // RULE7 RULE8
    rx_f.wdata = rx_word;
    tx_f.push = wr_now && (WB_ADR_I == `ADR_DATA) && WB_SEL_I[0]; // RULE9 RULE10
    tx_f.pop = 1'b0;
    tx_f.wdata = WB_DAT_I[7:0];
    rx_f.cap_one = !fifo_mode; // RULE20
    tx_f.cap_one = !fifo_mode; // RULE20
    if (wr_now) begin
      case (WB_ADR_I)
        `ADR_STAT_LOW: begin
          // write one to clear; a set in this same cycle below still wins
          if (WB_DAT_I[`B_FERR] && WB_SEL_I[1]) nxt_ferr = 1'b0;
          if (WB_DAT_I[`B_TUR] && WB_SEL_I[1]) nxt_tur = 1'b0;
          if (WB_DAT_I[`B_ROV] && WB_SEL_I[0]) nxt_rov = 1'b0;
        end
        `ADR_EVT_EN: nxt_evt = ((WB_DAT_I[15:0] & wmask) | (evt_ff & ~wmask)) & `STAT_MASK;
        `ADR_WMARK: nxt_wm = ((WB_DAT_I[15:0] & wmask) | (wm_ff & ~wmask)) & `WMARK_MASK;
        `ADR_CTRL: nxt_ctrl = ((WB_DAT_I[15:0] & wmask) | (ctrl_ff & ~wmask)) & `CTRL_MASK;
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    case (state_ff)
      LINK_IDLE: begin
        if (ss_act && en) begin
          nxt_state = LINK_SHIFT;
          nxt_bit = 3'h0;
          // a word kept in the shifter from the last frame goes out first
          take_tx = !loaded_ff;
        end
      end
      LINK_SHIFT: begin
        if (!ss_act) begin
          nxt_state = LINK_IDLE;
          nxt_pend = 1'b0;
          // a whole word waiting in the shifter survives the frame end; a cut one is dropped
          if (bit_ff != 3'h0) begin
            nxt_ferr = 1'b1; // RULE1
            nxt_loaded = 1'b0;
          end
        end else if (sck_rise) begin
          nxt_rxsh = rx_word;
          nxt_bit = bit_ff + 3'h1;
          if (pend_ff && bit_ff == 3'h0) begin
            nxt_pend = 1'b0;
            nxt_tur = 1'b1; // RULE3
            if (!ign_ur) nxt_state = LINK_HALT; // RULE4
          end
          if (bit_ff == 3'h7) begin
            byte_done = 1'b1;
            take_tx = 1'b1;
            if (rx_full && !rx_f.pop) begin
              nxt_rov = 1'b1; // RULE6
              if (!ign_ov) nxt_state = LINK_HALT; // RULE19
            end else begin
              rx_f.push = 1'b1; // RULE7 RULE8
            end
          end
        end else if (sck_fall && bit_ff != 3'h0) begin
          nxt_txsh = {txsh_ff[6:0], 1'b0};
        end
      end
      LINK_HALT: begin
        if (!ss_act && !(tur_ff && !ign_ur) && !(rov_ff && !ign_ov)) begin
          nxt_state = LINK_IDLE;
        end
        nxt_loaded = 1'b0;
      end
      default: nxt_state = LINK_IDLE;
    endcase
    if (take_tx && nxt_state == LINK_SHIFT) begin
      // a missing word is only an underrun once the master clocks it
      if (!tx_empty) begin
        tx_f.pop = 1'b1; // RULE9 RULE10
        nxt_txsh = tx_f.rdata;
        nxt_loaded = 1'b1;
        nxt_pend = 1'b0;
        if (ign_ur) nxt_tur = 1'b0; // RULE4
      end else begin
        nxt_txsh = 8'h00;
        nxt_loaded = 1'b0;
        nxt_pend = 1'b1;
      end
    end
    rx_f.flush = !en;
    tx_f.flush = !en;
    if (!en) begin
      nxt_state = LINK_IDLE;
      nxt_bit = 3'h0;
      nxt_loaded = 1'b0;
      nxt_pend = 1'b0;
      nxt_ferr = 1'b0;
      nxt_tur = 1'b0; // RULE4
      nxt_rov = 1'b0;
      rx_f.push = 1'b0;
      tx_f.push = 1'b0;
    end
    nxt_sdo = nxt_txsh[7];
    nxt_oe = ss_act && en;
    nxt_event = (|(stat_low & evt_ff)) || rx_wm || tx_wm; // RULE14 RULE21
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= LINK_IDLE;
      bit_ff <= 3'h0;
      rxsh_ff <= 8'h00;
      txsh_ff <= 8'h00;
      loaded_ff <= 1'b0;
      pend_ff <= 1'b0;
      ferr_ff <= 1'b0;
      tur_ff <= 1'b0;
      rov_ff <= 1'b0;
      ctrl_ff <= 16'h0000;
      evt_ff <= 16'h0000;
      wm_ff <= 16'h0000;
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bit_ff <= nxt_bit;
      rxsh_ff <= nxt_rxsh;
      txsh_ff <= nxt_txsh;
      loaded_ff <= nxt_loaded;
      pend_ff <= nxt_pend;
      ferr_ff <= nxt_ferr;
      tur_ff <= nxt_tur;
      rov_ff <= nxt_rov;
      ctrl_ff <= nxt_ctrl;
      evt_ff <= nxt_evt;
      wm_ff <= nxt_wm;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      sdo_ff <= nxt_sdo;
      oe_ff <= nxt_oe;
      event_ff <= nxt_event;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = dat_ff;
  assign SDO = sdo_ff;
  assign SDO_OE = oe_ff;
  assign EVENT_O = event_ff;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  sequence frame_cut_s;
    state_ff == LINK_SHIFT && !ss_act && bit_ff != 3'h0 && en;
  endsequence
  sequence rov_stop_s;
    en && byte_done && rx_full && !rx_f.pop && !ign_ov;
  endsequence
  sequence std_rx_fill_s;
    en && !fifo_mode && rx_f.push && rx_cnt == 6'h00;
  endsequence

  frame_err_set_a: assert property (frame_cut_s |=> ferr_ff) // RULE1
    else $error("frame error not flagged");
  busy_shown_a: assert property (bus_hit && !ack_ff && WB_ADR_I == `ADR_STAT_LOW // RULE2
    && state_ff == LINK_SHIFT |=> WB_DAT_O[`B_BUSY])
    else $error("activity flag low during transfer");
  tur_disable_a: assert property (!en |=> !tur_ff && !rov_ff) // RULE4
    else $error("flags survive disable");
  shift_reg_empty_flag_loaded_a: assert property (en && state_ff == LINK_SHIFT && !ss_act && bit_ff == 3'h0 // RULE5
    && loaded_ff |=> !stat_low[`B_SHIFT_REG_EMPTY_FLAG])
    else $error("shift empty while shifter loaded");
  rov_halts_a: assert property (rov_stop_s |=> rov_ff && state_ff == LINK_HALT) // RULE19
    else $error("overflow did not halt");
  std_rx_full_a: assert property (std_rx_fill_s ##1 !fifo_mode |-> stat_low[`B_RBF] && !stat_low[`B_RBE]) // RULE8
    else $error("single buffer rx flags wrong after fill");
  std_tx_write_a: assert property (en && !fifo_mode && tx_f.push && tx_empty && !tx_f.pop
    |=> !fifo_mode |-> stat_low[`B_TBF]) // RULE10
    else $error("tx full not set by write");
  rx_mark_evt_a: assert property (en && wm_ff[`B_RXWEN] && rx_lvl <= rx_cnt && rx_lvl <= `FIFO_DEPTH
    |=> EVENT_O) // RULE15
    else $error("rx watermark event missing");
  cnt_upper_zero_a: assert property (stat_high[15:12] == 4'h0 && stat_high[7:4] == 4'h0) // RULE13
    else $error("unimplemented count bits set");
  ack_pulse_a: assert property (WB_ACK_O |-> (WB_DAT_O[31:16] == 16'h0000) ##1 !WB_ACK_O) // RULE18
    else $error("ack held two cycles or upper read bits set");
endmodule
`default_nettype wire

// [status_fifo_dummy_guard.sv]
// intentionally empty compilation unit
`default_nettype none
`default_nettype wire

// [spi_master_model.sv]
// serial master model that drives the slave side of the status block
// assumes mode 0 framing with a 400 ns link clock that idles low between frames
`default_nettype none
module spi_master_model (
  // link
  output logic sck,
  output logic ss_n,
  output logic sdi,
  input wire logic sdo,
  // received word
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    sdi = 1'b0;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end
  // a short frame stops mid-word and reports nothing
  task automatic xfer(input logic [7:0] tx, input int nbits);
    #17 ss_n = 1'b0;
    #400;
    for (int i = 7; i > 7 - nbits; i--) begin
      sdi = tx[i];
      #200 sck = 1'b1;
      rx_byte = {rx_byte[6:0], sdo};
      #200 sck = 1'b0;
    end
    #200 ss_n = 1'b1;
    // a released line shows the inverse so a stale copy cannot pass
    sdi = ~sdi;
    rx_valid = (nbits == 8);
    #10 rx_valid = 1'b0;
    #400;
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
// self-checking bench for the serial port status block
// assumes a 20 MHz REF_CLK and the serial master model on the link
`include "spi_status_consts.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, cyc, stb, we, ack, sck, ss_n, sdi, sdo, sdo_oe, evt, rx_valid;
  logic [4:0] adr;
  logic [31:0] wdat, rdat, seed;
  logic [7:0] rx_byte;
  logic [31:0] rd_q[$];
  logic [8:0] ser_q[$];
  int fail_count, samples_checked;

  spi_status_top spi_status_top_inst (
    .REF_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SCK(sck), .SS_N(ss_n), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .EVENT_O(evt));
  spi_master_model spi_master_model_inst (
    .sck(sck), .ss_n(ss_n), .sdi(sdi), .sdo(sdo), .rx_byte(rx_byte), .rx_valid(rx_valid));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic fail(input string m);
    fail_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    // only the watchdog ends a wait for ack
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
    rd_q.push_back({e, m});
    wb(1'b0, a, 16'h0000);
  endtask

  task automatic cmp_rd();
    logic [31:0] n;
    n = rd_q.pop_front();
    samples_checked++;
    if ((rdat & {16'hffff, n[15:0]}) !== {16'h0000, n[31:16]}) fail("read data mismatch");
  endtask

  task automatic cmp_ser();
    logic [8:0] n;
    n = ser_q.pop_front();
    samples_checked++;
    if (n[8] && rx_byte !== n[7:0]) fail("serial output mismatch");
  endtask

  task automatic cmp_oe(input logic e);
    samples_checked++;
    if (sdo_oe !== e) fail("drive enable mismatch");
  endtask

  task automatic cmp_evt(input logic e);
    repeat (4) @(posedge clk);
    samples_checked++;
    if (evt !== e) fail("event level mismatch");
  endtask

  task automatic frame(input logic [7:0] e, input logic c, input int nb, output logic [7:0] s);
    seed = xs(seed);
    s = seed[7:0];
    if (nb == 8) ser_q.push_back({c, e});
    spi_master_model_inst.xfer(s, nb);
  endtask

  always @(posedge clk) if (cyc && !we && ack === 1'b1) cmp_rd();
  always @(posedge rx_valid) cmp_ser();

  initial begin
    #400000;
    fail("watchdog expired");
    close_out();
  end

  initial begin
    logic [7:0] b[8];
    logic [7:0] t[8];
    logic [7:0] x;
    int bits[9] = '{12, 11, 8, 7, 6, 5, 3, 1, 0};
    fail_count = 0;
    samples_checked = 0;
    seed = 32'd47433;
    {rst_n, cyc, stb, we, adr, wdat} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`ADR_STAT_LOW, 16'h00a8, 16'hffff);
    rd(`ADR_COUNTS, 16'h0000, 16'hffff);
    rd(`ADR_EVT_EN, 16'h0000, 16'hffff);
    rd(5'h18, 16'h0000, 16'hffff);
    wr(`ADR_EVT_EN, 16'hffff);
    rd(`ADR_EVT_EN, 16'h19eb, 16'hffff);
    wr(`ADR_WMARK, 16'hffff);
    rd(`ADR_WMARK, 16'h0000, 16'h4040);
    wr(`ADR_COUNTS, 16'hffff);
    rd(`ADR_COUNTS, 16'h0000, 16'hffff);
    wr(`ADR_EVT_EN, 16'h0000);
    wr(`ADR_WMARK, 16'h0000);
    // single-buffer mode
    wr(`ADR_CTRL, 16'h0001);
    seed = xs(seed);
    x = seed[7:0];
    wr(`ADR_DATA, {8'h00, x});
    rd(`ADR_STAT_LOW, 16'h0022, 16'h19eb);
    fork
      frame(x, 1'b1, 8, t[0]);
      begin
        #1500;
        rd(`ADR_STAT_LOW, 16'h0800, 16'h0800);
        cmp_oe(1'b1);
      end
    join
    cmp_oe(1'b0);
    rd(`ADR_STAT_LOW, 16'h0089, 16'h19eb);
    rd(`ADR_DATA, {8'h00, t[0]}, 16'h00ff);
    rd(`ADR_STAT_LOW, 16'h00a8, 16'h19eb);
    frame(8'h00, 1'b0, 8, x);
    rd(`ADR_STAT_LOW, 16'h0100, 16'h0100);
    wr(`ADR_CTRL, 16'h0000);
    rd(`ADR_STAT_LOW, 16'h0000, 16'h0100);
    wr(`ADR_CTRL, 16'h0001);
    wr(`ADR_DATA, 16'h005a);
    frame(8'h00, 1'b0, 4, x);
    rd(`ADR_STAT_LOW, 16'h1000, 16'h1000);
    wr(`ADR_STAT_LOW, 16'h1000);
    rd(`ADR_STAT_LOW, 16'h0000, 16'h1000);
    wr(`ADR_CTRL, 16'h0000);
    // both faults ignored: second word overflows and is dropped
    wr(`ADR_CTRL, 16'h000d);
    frame(8'h00, 1'b0, 8, t[0]);
    frame(8'h00, 1'b0, 8, t[1]);
    rd(`ADR_STAT_LOW, 16'h0041, 16'h0041);
    rd(`ADR_DATA, {8'h00, t[0]}, 16'h00ff);
    wr(`ADR_STAT_LOW, 16'h0040);
    rd(`ADR_STAT_LOW, 16'h0000, 16'h0040);
    wr(`ADR_CTRL, 16'h0000);
    // overflow not ignored: the port halts until the flag is cleared
    wr(`ADR_CTRL, 16'h0005);
    frame(8'h00, 1'b0, 8, t[0]);
    frame(8'h00, 1'b0, 8, t[1]);
    rd(`ADR_STAT_LOW, 16'h0041, 16'h0041);
    rd(`ADR_DATA, {8'h00, t[0]}, 16'h00ff);
    frame(8'h00, 1'b0, 8, t[1]);
    rd(`ADR_STAT_LOW, 16'h0060, 16'h0061);
    wr(`ADR_CTRL, 16'h0000);
    // fifo mode
    wr(`ADR_CTRL, 16'h0003);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      b[i] = seed[7:0];
      wr(`ADR_DATA, {8'h00, b[i]});
    end
    wr(`ADR_DATA, 16'h00ff);
    rd(`ADR_COUNTS, 16'h0008, 16'hffff);
    rd(`ADR_STAT_LOW, 16'h0022, 16'h002b);
    wr(`ADR_WMARK, 16'h0088);
    cmp_evt(1'b1);
    wr(`ADR_WMARK, 16'h0087);
    cmp_evt(1'b0);
    wr(`ADR_WMARK, 16'h0000);
    for (int i = 0; i < 8; i++) frame(b[i], 1'b1, 8, t[i]);
    rd(`ADR_COUNTS, 16'h0800, 16'hffff);
    rd(`ADR_STAT_LOW, 16'h0009, 16'h002b);
    wr(`ADR_WMARK, 16'h8300);
    cmp_evt(1'b1);
    wr(`ADR_WMARK, 16'h8900);
    cmp_evt(1'b0);
    wr(`ADR_WMARK, 16'h8800);
    cmp_evt(1'b1);
    wr(`ADR_WMARK, 16'h0000);
    for (int i = 0; i < 8; i++) rd(`ADR_DATA, {8'h00, t[i]}, 16'h00ff);
    rd(`ADR_COUNTS, 16'h0000, 16'hffff);
    // idle fifo mode shows only the three empty flags
    for (int i = 0; i < 9; i++) begin
      wr(`ADR_EVT_EN, 16'h0001 << bits[i]);
      cmp_evt(bits[i] inside {7, 5, 3});
    end
    wr(`ADR_EVT_EN, 16'h0000);
    cmp_evt(1'b0);
    close_out();
  end
endmodule
`default_nettype wire
